// ===== inc/bss_pkg.sv
// Purpose: Shared constants and types for the boot source selector
// Assumes: 32-bit register port with byte addresses on word boundaries
// Notes: Filter block words sit first, boot control and status after them
package bss_pkg;

  // First instruction fetch address
  localparam logic [23:0] BOOT_VECTOR = 24'h000000;

  // Internal ROM window once relocated
  localparam logic [23:0] ROM_WIN_LO = 24'hFF0000;
  localparam logic [23:0] ROM_WIN_HI = 24'hFF7FFF;

  // Address mode control fields
  localparam int ADDR_MODE_LSB = 0;
  localparam logic [1:0] ADDR_MODE_CONTIG = 2'h3;
  localparam int ADDR_MODE_STACK_BIT = 2;
  localparam int ADDR_MODE_ROMREL_BIT = 5;

  // Start-up configuration values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] PORT4_INIT = 8'h2F;
  localparam logic [7:0] PORT5_INIT = 8'h07;
  localparam logic [7:0] PORT6_INIT = 8'h27;
  localparam logic [7:0] MEMMAP_INIT = 8'hAF;
  localparam logic [2:0] STRETCH_MAX = 3'h7;

  // Cycles after reset release before pins are trusted (two sync stages plus one)
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // Register byte addresses
  localparam logic [7:0] REG_MASK0 = 8'h00;
  localparam logic [7:0] REG_MASK3 = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_OFFSET = 8'h14;
  localparam logic [7:0] REG_CRC01 = 8'h18;
  localparam logic [7:0] REG_CRC23 = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_CTL = 8'h24;

  // Field layout and reset values of the filter block
  localparam int MASK_TOP_BIT = 31;
  localparam logic [31:0] CMD_LIVE_BITS = 32'h0F0F0F0F;
  localparam int CMD_STRIDE = 8;
  localparam int CMD_ENABLE_BIT = 0;
  localparam int CMD_MCAST_BIT = 3;
  localparam logic [31:0] FILT_RESET = 32'h00000000;

  // Status and control fields
  localparam int STAT_PATH_LSB = 0;
  localparam int STAT_ROM_FETCH_BIT = 3;
  localparam int STAT_SKIP_BIT = 4;
  localparam int STAT_EA_BIT = 5;
  localparam int STAT_ROM_EN_BIT = 6;
  localparam int CTL_SKIP_BIT = 0;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'h0,
    ST_SELECT = 3'h1,
    ST_INIT = 3'h2,
    ST_STRAP = 3'h3,
    ST_ROM_RUN = 3'h4,
    ST_EXT_RUN = 3'h5
  } bss_state_type;

  typedef enum logic [2:0] {
    BP_NONE = 3'h0,
    BP_EXTERNAL = 3'h1,
    BP_LOADER = 3'h2,
    BP_NETWORK_BOOT = 3'h3,
    BP_FIND_CODE = 3'h4
  } bss_path_type;

endpackage

// ===== src/bss_sync2.sv
// Purpose: Two-stage synchroniser for one pin level
// Assumes: Pin changes slowly against mclk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module bss_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic d,
  output logic q
);

  logic meta_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ===== src/bss_boot_select.sv
// Purpose: Boot source selection, start-up configuration and wake-up filter block
// Assumes: por_nrst is low only at power-on; nrst is low for every reset
// Notes: Boot path is decided once per reset and then held
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Summary of operation
// - Every boot starts fetching at address 000000h in the chosen space.
// - External-access pin low forces external code and hides internal ROM.
// - Pin high with skip bit 0 runs internal ROM firmware.
// - Pin high with skip bit 1 runs external code from address zero.
// - Skip bit clears only at power-on; other resets keep it.
// - On ROM path, loader strap 1 selects serial loader watching port 0.
// - Loader strap 0: network_boot strap 0 starts network boot, 1 searches user code.
// - Init sets contiguous 24-bit addressing and the extended stack bit.
// - Init sets ROM relocation so ROM appears at FF0000h to FF7FFFh.
// - Init writes chip-select port controls 2Fh, 07h and 27h.
// - Init writes AFh to memory map and 111b stretch.
// - Filter block: four masks, command word, offset word, two CRC words.
// - Each command nibble: MSB picks unicast or multicast, LSB enables that filter.
// - Mask bit 31 reads 0; set mask bit j includes byte offset plus j.
module bss_boot_select (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic por_nrst,
  input wire logic ext_access_pin_n,
  input wire logic loader_strap_pin,
  input wire logic network_boot_strap_pin,
  input wire logic [23:0] cpu_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic fetch_start,
  output logic [23:0] fetch_addr,
  output logic fetch_rom,
  output logic rom_access_en,
  output logic rom_window_hit,
  output logic [2:0] boot_path,
  output logic serial_watch,
  output logic [7:0] addr_mode_ctl,
  output logic [7:0] port4_select_ctl,
  output logic [7:0] port5_select_ctl,
  output logic [7:0] port6_select_ctl,
  output logic [7:0] memory_map_ctl,
  output logic [7:0] stretch_timing_ctl,
  output logic [3:0] filter_enable,
  output logic [3:0] filter_mcast
);

  bss_pkg::bss_state_type state_r;
  bss_pkg::bss_state_type state_nxt;
  logic [1:0] settle_r;
  logic ea_s;
  logic loader_s;
  logic network_boot_s;
  logic run_r;
  logic rom_skip_r;
  logic [30:0] mask_r [4];
  logic [31:0] cmd_r;
  logic [31:0] offset_r;
  logic [31:0] crc01_r;
  logic [31:0] crc23_r;
  logic [31:0] rdata_nxt;
  logic fetch_start_r;
  logic [23:0] fetch_addr_r;
  logic fetch_rom_r;
  logic rom_access_en_r;
  logic rom_window_hit_r;
  logic [2:0] boot_path_r;
  logic serial_watch_r;
  logic [7:0] addr_mode_r;
  logic [7:0] port4_r;
  logic [7:0] port5_r;
  logic [7:0] port6_r;
  logic [7:0] memmap_r;
  logic [7:0] stretch_r;
  logic [31:0] rdata_r;

  // Pins come from outside the clock domain
  bss_sync2 #(.RESET_VAL(1'b0)) u_sync_ea (
    .mclk(mclk),
    .nrst(nrst),
    .d(ext_access_pin_n),
    .q(ea_s)
  );

  bss_sync2 #(.RESET_VAL(1'b0)) u_sync_loader (
    .mclk(mclk),
    .nrst(nrst),
    .d(loader_strap_pin),
    .q(loader_s)
  );

  bss_sync2 #(.RESET_VAL(1'b1)) u_sync_network_boot (
    .mclk(mclk),
    .nrst(nrst),
    .d(network_boot_strap_pin),
    .q(network_boot_s)
  );

  // Marks the end of any reset; gates writes to state that outlives reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 1'b0;
    end else begin
      run_r <= 1'b1;
    end
  end

  // Reset only from power-on so warm resets keep a bypass request
  always_ff @(posedge mclk or negedge por_nrst) begin
    if (!por_nrst) begin
      rom_skip_r <= 1'b0;
    end else if (run_r && reg_wr && reg_addr == bss_pkg::REG_CTL) begin
      rom_skip_r <= reg_wdata[bss_pkg::CTL_SKIP_BIT];
    end
  end

  // Settle counter lets synchronised pins reflect post-reset levels
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      settle_r <= 2'h0;
    end else if (state_r == bss_pkg::ST_SETTLE) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      bss_pkg::ST_SETTLE: begin
        if (settle_r == bss_pkg::SETTLE_CYC) begin
          state_nxt = bss_pkg::ST_SELECT;
        end
      end
      bss_pkg::ST_SELECT: begin
        if (!ea_s || rom_skip_r) begin
          state_nxt = bss_pkg::ST_EXT_RUN;
        end else begin
          state_nxt = bss_pkg::ST_INIT;
        end
      end
      bss_pkg::ST_INIT: state_nxt = bss_pkg::ST_STRAP;
      bss_pkg::ST_STRAP: state_nxt = bss_pkg::ST_ROM_RUN;
      bss_pkg::ST_ROM_RUN: state_nxt = bss_pkg::ST_ROM_RUN;
      bss_pkg::ST_EXT_RUN: state_nxt = bss_pkg::ST_EXT_RUN;
      default: state_nxt = bss_pkg::ST_SETTLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= bss_pkg::ST_SETTLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Fetch space selection; one start pulse per reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fetch_start_r <= 1'b0;
      fetch_addr_r <= bss_pkg::BOOT_VECTOR;
      fetch_rom_r <= 1'b0;
      rom_access_en_r <= 1'b0;
    end else begin
      fetch_start_r <= (state_r == bss_pkg::ST_SELECT);
      if (state_r == bss_pkg::ST_SELECT) begin
        fetch_addr_r <= bss_pkg::BOOT_VECTOR;
        fetch_rom_r <= ea_s && !rom_skip_r;
        rom_access_en_r <= ea_s;
      end
    end
  end

  // ROM path decision, taken once from the strap levels
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      boot_path_r <= bss_pkg::BP_NONE;
      serial_watch_r <= 1'b0;
    end else if (state_r == bss_pkg::ST_SELECT && (!ea_s || rom_skip_r)) begin
      boot_path_r <= bss_pkg::BP_EXTERNAL;
    end else if (state_r == bss_pkg::ST_STRAP) begin
      if (loader_s) begin
        boot_path_r <= bss_pkg::BP_LOADER;
        serial_watch_r <= 1'b1;
      end else if (!network_boot_s) begin
        boot_path_r <= bss_pkg::BP_NETWORK_BOOT;
      end else begin
        boot_path_r <= bss_pkg::BP_FIND_CODE;
      end
    end
  end

  // Start-up configuration written on the ROM path only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_mode_r <= bss_pkg::CFG_RESET;
      port4_r <= bss_pkg::CFG_RESET;
      port5_r <= bss_pkg::CFG_RESET;
      port6_r <= bss_pkg::CFG_RESET;
      memmap_r <= bss_pkg::CFG_RESET;
      stretch_r <= bss_pkg::CFG_RESET;
    end else if (state_r == bss_pkg::ST_INIT) begin
      addr_mode_r[bss_pkg::ADDR_MODE_LSB +: 2] <= bss_pkg::ADDR_MODE_CONTIG;
      addr_mode_r[bss_pkg::ADDR_MODE_STACK_BIT] <= 1'b1;
      addr_mode_r[bss_pkg::ADDR_MODE_ROMREL_BIT] <= 1'b1;
      port4_r <= bss_pkg::PORT4_INIT;
      port5_r <= bss_pkg::PORT5_INIT;
      port6_r <= bss_pkg::PORT6_INIT;
      memmap_r <= bss_pkg::MEMMAP_INIT;
      stretch_r[2:0] <= bss_pkg::STRETCH_MAX;
    end
  end

  // Relocated ROM window; never hit while the pin hides the ROM
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rom_window_hit_r <= 1'b0;
    end else begin
      rom_window_hit_r <= rom_access_en_r && addr_mode_r[bss_pkg::ADDR_MODE_ROMREL_BIT]
        && cpu_addr >= bss_pkg::ROM_WIN_LO && cpu_addr <= bss_pkg::ROM_WIN_HI;
    end
  end

  // Wake-up filter block; reserved bits are never stored so they read 0
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        mask_r[i] <= bss_pkg::FILT_RESET[30:0];
      end
      cmd_r <= bss_pkg::FILT_RESET;
      offset_r <= bss_pkg::FILT_RESET;
      crc01_r <= bss_pkg::FILT_RESET;
      crc23_r <= bss_pkg::FILT_RESET;
    end else if (reg_wr) begin
      if (reg_addr <= bss_pkg::REG_MASK3 && reg_addr[1:0] == 2'h0) begin
        mask_r[reg_addr[3:2]] <= reg_wdata[30:0];
      end
      if (reg_addr == bss_pkg::REG_CMD) begin
        cmd_r <= reg_wdata & bss_pkg::CMD_LIVE_BITS;
      end
      if (reg_addr == bss_pkg::REG_OFFSET) begin
        offset_r <= reg_wdata;
      end
      if (reg_addr == bss_pkg::REG_CRC01) begin
        crc01_r <= reg_wdata;
      end
      if (reg_addr == bss_pkg::REG_CRC23) begin
        crc23_r <= reg_wdata;
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_addr <= bss_pkg::REG_MASK3 && reg_addr[1:0] == 2'h0) begin
      rdata_nxt = {1'b0, mask_r[reg_addr[3:2]]};
    end else if (reg_addr == bss_pkg::REG_CMD) begin
      rdata_nxt = cmd_r;
    end else if (reg_addr == bss_pkg::REG_OFFSET) begin
      rdata_nxt = offset_r;
    end else if (reg_addr == bss_pkg::REG_CRC01) begin
      rdata_nxt = crc01_r;
    end else if (reg_addr == bss_pkg::REG_CRC23) begin
      rdata_nxt = crc23_r;
    end else if (reg_addr == bss_pkg::REG_STATUS) begin
      rdata_nxt[bss_pkg::STAT_PATH_LSB +: 3] = boot_path_r;
      rdata_nxt[bss_pkg::STAT_ROM_FETCH_BIT] = fetch_rom_r;
      rdata_nxt[bss_pkg::STAT_SKIP_BIT] = rom_skip_r;
      rdata_nxt[bss_pkg::STAT_EA_BIT] = ea_s;
      rdata_nxt[bss_pkg::STAT_ROM_EN_BIT] = rom_access_en_r;
    end else if (reg_addr == bss_pkg::REG_CTL) begin
      rdata_nxt[bss_pkg::CTL_SKIP_BIT] = rom_skip_r;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : 32'h00000000;
    end
  end

  // Per-filter command nibble decode
  for (genvar f = 0; f < 4; f++) begin : g_cmd
    assign filter_enable[f] = cmd_r[f * bss_pkg::CMD_STRIDE + bss_pkg::CMD_ENABLE_BIT];
    assign filter_mcast[f] = cmd_r[f * bss_pkg::CMD_STRIDE + bss_pkg::CMD_MCAST_BIT];
  end

  assign reg_rdata = rdata_r;
  assign fetch_start = fetch_start_r;
  assign fetch_addr = fetch_addr_r;
  assign fetch_rom = fetch_rom_r;
  assign rom_access_en = rom_access_en_r;
  assign rom_window_hit = rom_window_hit_r;
  assign boot_path = boot_path_r;
  assign serial_watch = serial_watch_r;
  assign addr_mode_ctl = addr_mode_r;
  assign port4_select_ctl = port4_r;
  assign port5_select_ctl = port5_r;
  assign port6_select_ctl = port6_r;
  assign memory_map_ctl = memmap_r;
  assign stretch_timing_ctl = stretch_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  fetch_vector_a: assert property (fetch_start_r |-> fetch_addr_r == 24'h000000
    && $past(state_r) == bss_pkg::ST_SELECT) else $error("boot fetch not at vector zero");

  ea_low_ext_a: assert property ((state_r == bss_pkg::ST_SELECT && !ea_s)
    |=> !fetch_rom_r && !rom_access_en_r && boot_path_r == bss_pkg::BP_EXTERNAL)
    else $error("internal ROM reachable with access pin low");

  rom_enter_a: assert property ((state_r == bss_pkg::ST_SELECT && ea_s && !rom_skip_r)
    |=> fetch_start_r && fetch_rom_r ##1 state_r == bss_pkg::ST_STRAP)
    else $error("ROM firmware not entered");

  rom_bypass_a: assert property ((state_r == bss_pkg::ST_SELECT && ea_s && rom_skip_r)
    |=> fetch_start_r && !fetch_rom_r && boot_path_r == bss_pkg::BP_EXTERNAL)
    else $error("ROM bypass not taken");

  skip_keep_a: assert property (@(posedge mclk) disable iff (!por_nrst)
    !run_r |=> $stable(rom_skip_r)) else $error("skip bit disturbed by reset");

  loader_sel_a: assert property ((state_r == bss_pkg::ST_STRAP && loader_s)
    |=> boot_path_r == bss_pkg::BP_LOADER && serial_watch_r)
    else $error("serial loader not selected");

  network_boot_sel_a: assert property ((state_r == bss_pkg::ST_STRAP && !loader_s)
    |=> boot_path_r == ($past(network_boot_s) ? bss_pkg::BP_FIND_CODE : bss_pkg::BP_NETWORK_BOOT))
    else $error("wrong network_boot strap decision");

  addr_mode_a: assert property ((state_r == bss_pkg::ST_INIT)
    |=> addr_mode_r[2:0] == 3'h7 ##2 addr_mode_r[2:0] == 3'h7)
    else $error("address mode not initialised");

  rom_reloc_a: assert property ((state_r == bss_pkg::ST_INIT)
    |=> addr_mode_r[5]) else $error("ROM relocation bit not set");

  port_ctl_a: assert property ((state_r == bss_pkg::ST_INIT)
    |=> port4_r == 8'h2F && port5_r == 8'h07 && port6_r == 8'h27)
    else $error("chip select controls wrong");

  mem_stretch_a: assert property ((state_r == bss_pkg::ST_INIT)
    |=> memmap_r == 8'hAF && stretch_r[2:0] == 3'h7)
    else $error("memory map or stretch wrong");

  mask_top_a: assert property ((reg_rd && reg_addr <= bss_pkg::REG_MASK3)
    |=> !rdata_r[31]) else $error("mask bit 31 read as one");

  path_hold_a: assert property ((state_r == bss_pkg::ST_ROM_RUN
    || state_r == bss_pkg::ST_EXT_RUN) |=> $stable(boot_path_r) && !fetch_start_r)
    else $error("boot path changed after decision");

endmodule

// ===== verification/bss_pin_model.sv
// Purpose: Far-side model of the external-access pin and the two boot straps
// Assumes: The bench sets the strap mode while reset is held, and once after the path is chosen
// Notes: Pins are pure levels; external program memory is not modelled
`timescale 1ns/1ps
module bss_pin_model (
  input wire logic [2:0] mode,
  output logic ext_access_pin_n,
  output logic loader_strap_pin,
  output logic network_boot_strap_pin
);
  // Board straps are static levels, so the selector may sample them late
  assign ext_access_pin_n = mode[2];
  assign loader_strap_pin = mode[1];
  assign network_boot_strap_pin = mode[0];
  // No loader commands are sent, as the host waits for banner and prompt first
endmodule

// ===== verification/bss_boot_select_tb.sv
// Purpose: Self-checking bench for the boot source selector
// Assumes: Strap levels stay steady from reset release until the path is chosen
// Notes: Boot cases share one task; the filter block is written and read back
`timescale 1ns/1ps
module bss_boot_select_tb;
  logic mclk, nrst, por_nrst, reg_wr, reg_rd;
  logic [2:0] mode;
  logic [23:0] cpu_addr, fetch_addr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic fetch_start, fetch_rom, rom_access_en, rom_window_hit, serial_watch;
  logic ext_access_pin_n, loader_strap_pin, network_boot_strap_pin;
  logic [2:0] boot_path;
  logic [7:0] addr_mode_ctl, port4_select_ctl, port5_select_ctl, port6_select_ctl;
  logic [7:0] memory_map_ctl, stretch_timing_ctl;
  logic [3:0] filter_enable, filter_mcast;
  logic [23:0] hit_addr [4] = '{24'hFEFFFF, 24'hFF0000, 24'hFF7FFF, 24'hFF8000};
  int n_fail, n_checks;

  bss_pin_model pins (.mode(mode), .ext_access_pin_n(ext_access_pin_n),
    .loader_strap_pin(loader_strap_pin), .network_boot_strap_pin(network_boot_strap_pin));

  bss_boot_select uut (.mclk(mclk), .nrst(nrst), .por_nrst(por_nrst),
    .ext_access_pin_n(ext_access_pin_n), .loader_strap_pin(loader_strap_pin),
    .network_boot_strap_pin(network_boot_strap_pin), .cpu_addr(cpu_addr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_start(fetch_start), .fetch_addr(fetch_addr), .fetch_rom(fetch_rom),
    .rom_access_en(rom_access_en), .rom_window_hit(rom_window_hit),
    .boot_path(boot_path), .serial_watch(serial_watch), .addr_mode_ctl(addr_mode_ctl),
    .port4_select_ctl(port4_select_ctl), .port5_select_ctl(port5_select_ctl),
    .port6_select_ctl(port6_select_ctl), .memory_map_ctl(memory_map_ctl),
    .stretch_timing_ctl(stretch_timing_ctl), .filter_enable(filter_enable),
    .filter_mcast(filter_mcast));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just there
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic hit(input logic [23:0] a);
    @(posedge mclk);
    cpu_addr <= a;
    @(posedge mclk);
    #1;
  endtask

  // Mode is {ext access pin, loader strap, network_boot strap}
  task automatic boot(input logic [2:0] m, input logic por, input logic skip,
    input logic [2:0] path);
    int k;
    logic rom;
    rom = m[2] & ~skip;
    @(posedge mclk);
    mode <= m;
    nrst <= 1'b0;
    por_nrst <= ~por;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    por_nrst <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (fetch_start !== 1'b1 && k < 40);
    chk(32'(k < 40), 32'h1);
    chk(32'(fetch_addr), 32'h0);
    chk(32'(fetch_rom), 32'(rom));
    @(posedge mclk);
    #1;
    chk(32'(fetch_start), 32'h0);
    repeat (5) @(posedge mclk);
    #1;
    chk(32'(boot_path), 32'(path));
    chk(32'(serial_watch), 32'(path == 3'h2));
    chk(32'(rom_access_en), 32'(m[2]));
    chk({addr_mode_ctl, port4_select_ctl, port5_select_ctl, port6_select_ctl},
      rom ? 32'h272F0727 : 32'h0);
    chk({16'h0, memory_map_ctl, stretch_timing_ctl}, rom ? 32'hAF07 : 32'h0);
    rd(bss_pkg::REG_STATUS);
    chk(rd_val, {25'h0, m[2], m[2], skip, rom, path});
  endtask

  initial begin
    logic [31:0] v;
    n_fail = 0;
    n_checks = 0;
    nrst = 1'b0;
    por_nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    cpu_addr = 24'h0;
    mode = 3'h7;
    boot(3'h7, 1'b1, 1'b0, 3'h2);
    // Straps moving after the decision must not disturb the chosen path
    mode <= 3'h4;
    repeat (10) @(posedge mclk);
    #1;
    chk(32'(boot_path), 32'h2);
    for (int i = 0; i < 4; i++) begin
      hit(hit_addr[i]);
      chk(32'(rom_window_hit), 32'(i == 1 || i == 2));
    end
    rd(bss_pkg::REG_CMD);
    chk(rd_val, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = 32'hC3A55A30 + 32'(i);
      wr(8'(4 * i), v);
      rd(8'(4 * i));
      chk(rd_val, (i < 4) ? {1'b0, v[30:0]} : (i == 4) ? (v & 32'h0F0F0F0F) : v);
    end
    wr(bss_pkg::REG_CMD, 32'h08010900);
    #1;
    chk({24'h0, filter_mcast, filter_enable}, 32'hA6);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40);
    chk(rd_val, 32'h0);
    wr(bss_pkg::REG_CTL, 32'h1);
    rd(bss_pkg::REG_CTL);
    chk(rd_val, 32'h1);
    boot(3'h7, 1'b0, 1'b1, 3'h1);
    boot(3'h3, 1'b0, 1'b1, 3'h1);
    hit(24'hFF0000);
    chk(32'(rom_window_hit), 32'h0);
    boot(3'h4, 1'b1, 1'b0, 3'h3);
    rd(bss_pkg::REG_CTL);
    chk(rd_val, 32'h0);
    boot(3'h5, 1'b0, 1'b0, 3'h4);
    report_and_stop();
  end

  // The whole run needs about 1300 ns; a hang runs far past this
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule
